//--- include/mil_pkg.sv
// constants for the microcontroller interrupt request logic
// assumes an apb slave with 32-bit data, one aligned word per register
package mil_pkg;

  localparam int unsigned PIN_N = 6;
  localparam int unsigned PC_W = 13;
  localparam int unsigned SYNC_DEPTH = 3;

  // register byte offsets
  localparam logic [7:0] REG_INTERRUPT_CONTROL = 8'h00;
  localparam logic [7:0] REG_PCFLAG = 8'h04;
  localparam logic [7:0] REG_FALLEN = 8'h08;
  localparam logic [7:0] REG_RISEEN = 8'h0c;
  localparam logic [7:0] REG_LATCH = 8'h10;
  localparam logic [7:0] REG_PIE = 8'h14;
  localparam logic [7:0] REG_PIR = 8'h18;
  localparam logic [7:0] REG_OPTION = 8'h1c;
  localparam logic [7:0] REG_ANALOG = 8'h20;
  localparam logic [7:0] REG_PORTIN = 8'h24;

  // interrupt_control fields
  localparam int unsigned IC_GIE = 7;
  localparam int unsigned IC_PERIPHERAL_IRQ_GATE = 6;
  localparam int unsigned IC_TIMER_ZERO_OVERFLOW_ENABLE = 5;
  localparam int unsigned IC_EXT_PIN_ENABLE = 4;
  localparam int unsigned IC_PORT_CHANGE_ENABLE = 3;
  localparam int unsigned IC_TIMER_ZERO_OVERFLOW_FLAG = 2;
  localparam int unsigned IC_EXT_PIN_FLAG = 1;
  localparam int unsigned IC_PORT_CHANGE_FLAG = 0;

  // option register: edge polarity bit
  localparam int unsigned OPT_EDGE = 6;

  // ext interrupt pin sits on port bit 2
  localparam int unsigned EXT_PIN_IDX = 2;

  // implemented bits
  localparam logic [7:0] PERIPH_MASK = 8'hcf;
  localparam logic [5:0] LATCH_MASK = 6'h37;

  // reset values
  localparam logic [7:0] INTERRUPT_CONTROL_RST = 8'h00;
  localparam logic [7:0] PERIPH_RST = 8'h00;
  localparam logic [5:0] PIN_CFG_RST = 6'h00;
  localparam logic [5:0] ANALOG_RST = 6'h3f;
  localparam logic EDGE_RST = 1'b1;

  localparam logic [PC_W-1:0] IRQ_VECTOR = 13'h0004;

  localparam logic [7:0] TMR_MAX = 8'hff;
  localparam logic [7:0] TMR_ZERO = 8'h00;

  // quarter-cycle phases of the instruction cycle
  localparam logic [1:0] PH_Q1 = 2'h0;
  localparam logic [1:0] PH_Q4 = 2'h3;
  localparam logic [1:0] PH_STEP = 2'h1;

  localparam logic [31:0] RD_ZERO = 32'h0000_0000;

endpackage

//--- verilog/mil_sync3.sv
// three-stage input synchroniser with agreement filter
// assumes asynchronous pin inputs; value moves once stages two and three agree
`timescale 1ns/1ns
module mil_sync3
  import mil_pkg::*;
#(
  parameter int unsigned WIDTH = PIN_N
) (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] stable_o
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] next_stable;

  always_comb begin
    next_stable = stable_o;
    for (int i = 0; i < WIDTH; i++) begin
      if (stage2[i] == stage3[i]) begin
        next_stable[i] = stage3[i];
      end
    end
  end

  // stage1 feeds stage2 only
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      stable_o <= '0;
    end else begin
      stage1 <= pin_i;
      stage2 <= stage1;
      stage3 <= stage2;
      stable_o <= next_stable;
    end
  end

endmodule

//--- verilog/mil_irq_top.sv
// interrupt request logic: flags, enables, vectored request and wake
// assumes an apb master, a cpu core giving ack and return strobes,
// and a timer count and peripheral event pulses on this same clock
//
// Added by the designer: register access over APB and the register offsets.
`timescale 1ns/1ns
module mil_irq_top
  import mil_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [PIN_N-1:0] port_a_pins_i,
  input wire logic [7:0] timer_zero_count_i,
  input wire logic [7:0] periph_event_i,
  input wire logic port_access_i,
  input wire logic sleep_i,
  input wire logic irq_ack_i,
  input wire logic return_from_irq_instr_i,
  output logic irq_request_o,
  output logic wake_o,
  output logic stack_push_o,
  output logic pc_load_o,
  output logic [PC_W-1:0] vector_o,
  output logic [PIN_N-1:0] port_output_latch_o
);

  ////////////////////////////////////////////////////////////////////
  // helpers

  // hardware set wins over a software clear in the same cycle
  function automatic logic [7:0] flag_upd(input logic [7:0] cur,
                                          input logic [7:0] set,
                                          input logic [7:0] keep);
    flag_upd = set | (cur & keep);
  endfunction

  function automatic logic is_mapped(input logic [7:0] addr);
    is_mapped = (addr == REG_INTERRUPT_CONTROL) || (addr == REG_PCFLAG) ||
                (addr == REG_FALLEN) || (addr == REG_RISEEN) ||
                (addr == REG_LATCH) || (addr == REG_PIE) ||
                (addr == REG_PIR) || (addr == REG_OPTION) ||
                (addr == REG_ANALOG) || (addr == REG_PORTIN);
  endfunction

  ////////////////////////////////////////////////////////////////////
  // state

  logic [PIN_N-1:0] pins_stable;
  logic [7:0] interrupt_control;
  logic [PIN_N-1:0] pin_change_flags;
  logic [PIN_N-1:0] pin_fall_detect_enable;
  logic [PIN_N-1:0] pin_rise_detect_enable;
  logic [7:0] peripheral_irq_enable_one;
  logic [7:0] peripheral_irq_flag_one;
  logic ext_irq_edge_polarity;
  logic [PIN_N-1:0] analog_select;
  logic [PIN_N-1:0] pins_prev;
  logic [7:0] timer_prev;
  logic ext_edge_pend;
  logic [1:0] q_phase;
  logic sleep_prev;
  logic ext_en_at_sleep;

  logic [7:0] next_interrupt_control;
  logic [PIN_N-1:0] next_pin_change_flags;
  logic [PIN_N-1:0] next_pin_fall_detect_enable;
  logic [PIN_N-1:0] next_pin_rise_detect_enable;
  logic [PIN_N-1:0] next_port_output_latch;
  logic [7:0] next_peripheral_irq_enable_one;
  logic [7:0] next_peripheral_irq_flag_one;
  logic next_ext_irq_edge_polarity;
  logic [PIN_N-1:0] next_analog_select;
  logic next_ext_edge_pend;
  logic [1:0] next_q_phase;
  logic next_ext_en_at_sleep;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic next_irq_request;
  logic next_wake;
  logic next_stack_push;
  logic next_pc_load;

  logic [PIN_N-1:0] pins_eff;
  logic [PIN_N-1:0] pin_rise;
  logic [PIN_N-1:0] pin_fall;
  logic [PIN_N-1:0] pin_event;
  logic ext_rise;
  logic ext_fall;
  logic ext_edge;
  logic ext_window;
  logic tmr_roll;
  logic wr_en;
  logic [7:0] wbyte;
  logic [7:0] ic_keep;
  logic [7:0] ic_set;
  logic [7:0] ic_live;
  logic periph_any;
  logic src_ext;
  logic src_tmr;
  logic src_ioc;
  logic take_irq;
  logic [7:0] pcf_upd;

  ////////////////////////////////////////////////////////////////////
  // pin conditioning

  mil_sync3 #(
    .WIDTH(PIN_N)
  ) u_pin_sync (
    .clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i),
    .pin_i(port_a_pins_i),
    .stable_o(pins_stable)
  );

  always_comb begin
    pins_eff = pins_stable & ~analog_select;
    pin_rise = pins_eff & ~pins_prev & pin_rise_detect_enable;
    pin_fall = ~pins_eff & pins_prev & pin_fall_detect_enable;
    // a change landing during a port access is dropped
    pin_event = port_access_i ? '0 : (pin_rise | pin_fall);
    ext_rise = pins_eff[EXT_PIN_IDX] & ~pins_prev[EXT_PIN_IDX];
    ext_fall = ~pins_eff[EXT_PIN_IDX] & pins_prev[EXT_PIN_IDX];
    ext_edge = ext_irq_edge_polarity ? ext_rise : ext_fall;
    ext_window = (q_phase == PH_Q4) || (q_phase == PH_Q1);
    tmr_roll = (timer_prev == TMR_MAX) && (timer_zero_count_i == TMR_ZERO);
  end

  ////////////////////////////////////////////////////////////////////
  // register and flag next values

  always_comb begin
    wr_en = psel_i & penable_i & pready_o & pwrite_i;
    wbyte = pwdata_i[7:0];
    next_q_phase = q_phase + PH_STEP;

    // the ext edge waits for the Q4-Q1 window before setting the flag
    next_ext_edge_pend = (ext_edge_pend | ext_edge) & ~ext_window;

    ic_set = '0;
    ic_set[IC_EXT_PIN_FLAG] = (ext_edge_pend | ext_edge) & ext_window;
    ic_set[IC_TIMER_ZERO_OVERFLOW_FLAG] = tmr_roll;
    ic_keep = '1;
    if (wr_en && paddr_i == REG_INTERRUPT_CONTROL) begin
      ic_keep = wbyte;
    end
    next_interrupt_control = flag_upd(interrupt_control, '0, ic_keep) |
                             (wr_en && paddr_i == REG_INTERRUPT_CONTROL ? wbyte : '0);
    next_interrupt_control[IC_EXT_PIN_FLAG] =
      ic_set[IC_EXT_PIN_FLAG] | (interrupt_control[IC_EXT_PIN_FLAG] & ic_keep[IC_EXT_PIN_FLAG]);
    next_interrupt_control[IC_TIMER_ZERO_OVERFLOW_FLAG] =
      ic_set[IC_TIMER_ZERO_OVERFLOW_FLAG] | (interrupt_control[IC_TIMER_ZERO_OVERFLOW_FLAG] & ic_keep[IC_TIMER_ZERO_OVERFLOW_FLAG]);
    // bit 0 mirrors the per-pin flags and is not stored
    next_interrupt_control[IC_PORT_CHANGE_FLAG] = 1'b0;

    take_irq = irq_ack_i & irq_request_o;
    if (take_irq) begin
      next_interrupt_control[IC_GIE] = 1'b0;
    end else if (return_from_irq_instr_i) begin
      next_interrupt_control[IC_GIE] = 1'b1;
    end

    pcf_upd = flag_upd({2'h0, pin_change_flags}, {2'h0, pin_event},
      (wr_en && paddr_i == REG_PCFLAG) ? wbyte : 8'hff);
    next_pin_change_flags = pcf_upd[PIN_N-1:0];
    next_peripheral_irq_flag_one = flag_upd(peripheral_irq_flag_one,
      periph_event_i & PERIPH_MASK,
      (wr_en && paddr_i == REG_PIR) ? wbyte : 8'hff) & PERIPH_MASK;

    next_pin_fall_detect_enable = pin_fall_detect_enable;
    next_pin_rise_detect_enable = pin_rise_detect_enable;
    next_port_output_latch = port_output_latch_o;
    next_peripheral_irq_enable_one = peripheral_irq_enable_one;
    next_ext_irq_edge_polarity = ext_irq_edge_polarity;
    next_analog_select = analog_select;
    if (wr_en) begin
      unique case (paddr_i)
        REG_FALLEN: begin
          next_pin_fall_detect_enable = wbyte[PIN_N-1:0];
        end
        REG_RISEEN: begin
          next_pin_rise_detect_enable = wbyte[PIN_N-1:0];
        end
        REG_LATCH: begin
          next_port_output_latch = wbyte[PIN_N-1:0] & LATCH_MASK;
        end
        REG_PIE: begin
          next_peripheral_irq_enable_one = wbyte & PERIPH_MASK;
        end
        REG_OPTION: begin
          next_ext_irq_edge_polarity = wbyte[OPT_EDGE];
        end
        REG_ANALOG: begin
          next_analog_select = wbyte[PIN_N-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // request, wake and service

  always_comb begin
    ic_live = interrupt_control;
    ic_live[IC_PORT_CHANGE_FLAG] = |pin_change_flags;
    src_tmr = ic_live[IC_TIMER_ZERO_OVERFLOW_FLAG] & ic_live[IC_TIMER_ZERO_OVERFLOW_ENABLE];
    src_ioc = ic_live[IC_PORT_CHANGE_FLAG] & ic_live[IC_PORT_CHANGE_ENABLE];
    // ext enable must have been set before sleep to wake it
    src_ext = ic_live[IC_EXT_PIN_FLAG] & ic_live[IC_EXT_PIN_ENABLE] &
              (~sleep_i | ext_en_at_sleep);
    periph_any = ic_live[IC_PERIPHERAL_IRQ_GATE] &
                 (|(peripheral_irq_flag_one & peripheral_irq_enable_one));
    next_irq_request = ic_live[IC_GIE] &
                       (src_ext | src_tmr | src_ioc | periph_any);
    // a taken request drops at once so it is not taken twice
    if (take_irq) begin
      next_irq_request = 1'b0;
    end
    next_wake = src_ext | src_tmr | src_ioc | periph_any;
    next_ext_en_at_sleep = ext_en_at_sleep;
    if (sleep_i && !sleep_prev) begin
      next_ext_en_at_sleep = interrupt_control[IC_EXT_PIN_ENABLE];
    end
    // only the return pc goes to the stack; no other context is saved
    next_stack_push = take_irq;
    next_pc_load = take_irq;
  end

  ////////////////////////////////////////////////////////////////////
  // apb slave: zero wait states, answer in the first access cycle

  always_comb begin
    next_pready = psel_i & ~penable_i;
    next_pslverr = psel_i & ~penable_i & ~is_mapped(paddr_i);
    next_prdata = RD_ZERO;
    // read data is sampled at setup; a flag set in between shows next read
    if (psel_i && !penable_i && !pwrite_i) begin
      unique case (paddr_i)
        REG_INTERRUPT_CONTROL: begin
          next_prdata[7:0] = ic_live;
        end
        REG_PCFLAG: begin
          next_prdata[PIN_N-1:0] = pin_change_flags;
        end
        REG_FALLEN: begin
          next_prdata[PIN_N-1:0] = pin_fall_detect_enable;
        end
        REG_RISEEN: begin
          next_prdata[PIN_N-1:0] = pin_rise_detect_enable;
        end
        REG_LATCH: begin
          next_prdata[PIN_N-1:0] = port_output_latch_o;
        end
        REG_PIE: begin
          next_prdata[7:0] = peripheral_irq_enable_one;
        end
        REG_PIR: begin
          next_prdata[7:0] = peripheral_irq_flag_one;
        end
        REG_OPTION: begin
          next_prdata[OPT_EDGE] = ext_irq_edge_polarity;
        end
        REG_ANALOG: begin
          next_prdata[PIN_N-1:0] = analog_select;
        end
        REG_PORTIN: begin
          next_prdata[PIN_N-1:0] = pins_eff;
        end
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      interrupt_control <= INTERRUPT_CONTROL_RST;
      pin_change_flags <= PIN_CFG_RST;
      pin_fall_detect_enable <= PIN_CFG_RST;
      pin_rise_detect_enable <= PIN_CFG_RST;
      port_output_latch_o <= PIN_CFG_RST;
      peripheral_irq_enable_one <= PERIPH_RST;
      peripheral_irq_flag_one <= PERIPH_RST;
      ext_irq_edge_polarity <= EDGE_RST;
      analog_select <= ANALOG_RST;
      pins_prev <= PIN_CFG_RST;
      timer_prev <= TMR_ZERO;
      ext_edge_pend <= 1'b0;
      q_phase <= PH_Q1;
      sleep_prev <= 1'b0;
      ext_en_at_sleep <= 1'b0;
      prdata_o <= RD_ZERO;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      irq_request_o <= 1'b0;
      wake_o <= 1'b0;
      stack_push_o <= 1'b0;
      pc_load_o <= 1'b0;
      vector_o <= IRQ_VECTOR;
    end else begin
      interrupt_control <= next_interrupt_control;
      pin_change_flags <= next_pin_change_flags;
      pin_fall_detect_enable <= next_pin_fall_detect_enable;
      pin_rise_detect_enable <= next_pin_rise_detect_enable;
      port_output_latch_o <= next_port_output_latch;
      peripheral_irq_enable_one <= next_peripheral_irq_enable_one;
      peripheral_irq_flag_one <= next_peripheral_irq_flag_one;
      ext_irq_edge_polarity <= next_ext_irq_edge_polarity;
      analog_select <= next_analog_select;
      pins_prev <= pins_eff;
      timer_prev <= timer_zero_count_i;
      ext_edge_pend <= next_ext_edge_pend;
      q_phase <= next_q_phase;
      sleep_prev <= sleep_i;
      ext_en_at_sleep <= next_ext_en_at_sleep;
      prdata_o <= next_prdata;
      pready_o <= next_pready;
      pslverr_o <= next_pslverr;
      irq_request_o <= next_irq_request;
      wake_o <= next_wake;
      stack_push_o <= next_stack_push;
      pc_load_o <= next_pc_load;
      vector_o <= IRQ_VECTOR;
    end
  end

endmodule

//--- verif/mil_irq_sva.sv
// assertions on the ports of the interrupt request logic
// assumes one clock domain and the zero-wait apb slave of the top module
`timescale 1ns/1ns
module mil_irq_sva
  import mil_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic sleep_i,
  input wire logic irq_ack_i,
  input wire logic irq_request_o,
  input wire logic wake_o,
  input wire logic stack_push_o,
  input wire logic pc_load_o,
  input wire logic [PC_W-1:0] vector_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!nrst_i);
  sequence taken;
    irq_ack_i && irq_request_o;
  endsequence
  //////////////////////////////////////////////////////////////////
  a_ack_service: assert property (taken |=> stack_push_o && pc_load_o)
    else $error("ack taken without push and load");
  a_ack_masks: assert property (taken |=> !irq_request_o)
    else $error("request still up after ack");
  a_push_cause: assert property ($rose(stack_push_o) |-> $past(irq_ack_i && irq_request_o))
    else $error("push without a taken ack");
  a_push_single: assert property (stack_push_o |=> !stack_push_o)
    else $error("push wider than one cycle");
  a_push_load: assert property (stack_push_o == pc_load_o)
    else $error("push and load apart");
  a_vector_fixed: assert property (pc_load_o |-> vector_o == IRQ_VECTOR)
    else $error("wrong vector at load");
  a_req_wakes: assert property (irq_request_o && !sleep_i |-> wake_o)
    else $error("request without wake");
  a_setup_ready: assert property (psel_i && !penable_i |=> pready_o ##1 !pready_o)
    else $error("ready not one cycle after setup");
  a_err_zero: assert property (pslverr_o |-> pready_o && prdata_o == RD_ZERO)
    else $error("error answer with data");
  // only the low byte carries register bits
  a_rd_upper: assert property (pready_o |-> prdata_o[31:8] == 24'h000000)
    else $error("upper read bits set");
  c_taken: cover property (taken);
  c_error: cover property (pslverr_o);
  c_sleep_wake: cover property (sleep_i && wake_o);
endmodule
bind mil_irq_top mil_irq_sva mil_irq_sva_i (
  .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .psel_i(psel_i), .penable_i(penable_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .sleep_i(sleep_i),
  .irq_ack_i(irq_ack_i), .irq_request_o(irq_request_o), .wake_o(wake_o),
  .stack_push_o(stack_push_o), .pc_load_o(pc_load_o), .vector_o(vector_o)
);

//--- verif/mil_core_model.sv
// cpu core model: takes requests after a set lag, counts pushes, issues returns
// assumes the interrupt logic shares its clock
`timescale 1ns/1ns
module mil_core_model (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic irq_request_i,
  input wire logic stack_push_i,
  input wire logic signed [31:0] lag_i,
  output logic irq_ack_o,
  output logic return_o,
  output int pushes_o
);
  int waited;
  initial return_o = 1'b0;
  //////////////////////////////////////////////////////////////////
  // negative lag: core leaves requests pending, as when busy
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_ack_o <= 1'b0;
      waited <= 0;
      pushes_o <= 0;
    end else begin
      irq_ack_o <= 1'b0;
      if (stack_push_i) pushes_o <= pushes_o + 1;
      if (irq_request_i && lag_i >= 0 && !irq_ack_o) begin
        if (waited >= lag_i) begin
          irq_ack_o <= 1'b1;
          waited <= 0;
        end else waited <= waited + 1;
      end
    end
  end
  task automatic ret();
    @(posedge clk_sys_i);
    return_o <= 1'b1;
    @(posedge clk_sys_i);
    return_o <= 1'b0;
  endtask
endmodule

//--- verif/tb.sv
// self-checking bench for the interrupt request logic
// assumes the core model answers requests; inputs change after rising edges
`timescale 1ns/1ns
module tb;
  import mil_pkg::*;
  logic clk_sys_i, nrst_i, psel, pen, pwr, pacc, slp, ack, ret, rdy, err, perr;
  logic irq, wake, push, load;
  logic [7:0] pa, tmr, pev;
  logic [31:0] pwd, prd, rd;
  logic [5:0] pins, latch;
  logic [12:0] vec;
  int lag, pushes, n_mismatch, checks_done, i, k;
  int m[10];
  int wm[10] = '{0, 0, 'h3f, 'h3f, 'h37, 'hcf, 0, 'h40, 'h3f, 0};
  mil_irq_top mil_irq_top_i (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd), .pready_o(rdy),
    .pslverr_o(err), .port_a_pins_i(pins), .timer_zero_count_i(tmr),
    .periph_event_i(pev), .port_access_i(pacc), .sleep_i(slp), .irq_ack_i(ack),
    .return_from_irq_instr_i(ret), .irq_request_o(irq), .wake_o(wake),
    .stack_push_o(push), .pc_load_o(load), .vector_o(vec), .port_output_latch_o(latch)
  );
  mil_core_model mil_core_model_i (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .irq_request_i(irq), .stack_push_i(push),
    .lag_i(lag), .irq_ack_o(ack), .return_o(ret), .pushes_o(pushes)
  );
  initial begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end
  //////////////////////////////////////////////////////////////////
  task automatic conclude();
    if (n_mismatch == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk_sys_i);
    pen <= 1'b1;
    // request holds until ready is seen high at a rising edge
    @(posedge clk_sys_i);
    while (rdy !== 1'b1) @(posedge clk_sys_i);
    rd = prd;
    perr = err;
    psel <= 1'b0;
    pen <= 1'b0;
    // idle edge so a following call never re-drives psel in the same step
    @(posedge clk_sys_i);
  endtask
  // model follows each write: flags clear on zero and a write never sets them
  task automatic wr(input int i, input int d);
    apb(1'b1, 8'(i * 4), 32'(d));
    if (i == 0) m[0] = (d & 'hf8) | (m[0] & d & 'h06);
    else if (i == 1 || i == 6) m[i] = m[i] & d;
    else m[i] = d & wm[i];
  endtask
  task automatic rdchk(input int i);
    int e;
    e = m[i];
    if (i == 0) e = m[0] | int'(m[1] != 0);
    if (i == 9) e = pins & ~m[8] & 'h3f;
    apb(1'b0, 8'(i * 4), '0);
    chk(rd, 32'(e));
  endtask
  // sync plus phase window plus flag fit in twelve cycles
  task automatic pin(input int b, input logic v);
    pins[b] <= v;
    wt(12);
  endtask
  //////////////////////////////////////////////////////////////////
  initial begin
    {psel, pen, pwr, pacc, slp} = '0;
    pa = '0; pwd = '0; tmr = '0; pev = '0; pins = '0;
    lag = 0; n_mismatch = 0; checks_done = 0;
    m = '{default: 0};
    m[7] = 'h40;
    m[8] = 'h3f;
    nrst_i = 1'b0;
    wt(6);
    nrst_i <= 1'b1;
    wt(1);
    void'($urandom(81));
    for (i = 0; i < 10; i++) rdchk(i);
    for (i = 0; i < 3; i++) begin
      k = $urandom;
      wr(4, k);
      rdchk(4);
      chk(32'(latch), 32'(k & 'h37));
      wr(5, $urandom);
      rdchk(5);
    end
    apb(1'b1, 8'h28, 32'hff);
    chk(32'(perr), 1);
    apb(1'b0, 8'h28, '0);
    chk(32'(perr), 1);
    chk(rd, 0);
    tmr <= TMR_MAX;
    wt(1);
    tmr <= TMR_ZERO;
    wt(2);
    m[0] |= 'h04;
    rdchk(0);
    chk(32'(irq), 0);
    wr(0, 'ha4);
    wt(5);
    chk(32'(pushes), 1);
    m[0] &= 'h7f;
    rdchk(0);
    chk(32'(irq), 0);
    lag = -1;
    mil_core_model_i.ret();
    wt(3);
    m[0] |= 'h80;
    chk(32'(irq), 1);
    rdchk(0);
    wr(0, 'ha0);
    wt(2);
    chk(32'(irq), 0);
    wr(0, 'h20);
    tmr <= TMR_MAX;
    wt(1);
    tmr <= TMR_ZERO;
    wt(3);
    m[0] |= 'h04;
    chk(32'(wake), 1);
    chk(32'(irq), 0);
    wr(8, 0);
    wr(0, 'h80);
    pin(2, 1'b1);
    m[0] |= 2;
    rdchk(0);
    chk(32'(irq), 0);
    rdchk(9);
    wr(0, 'h80);
    wr(7, 0);
    pin(2, 1'b0);
    m[0] |= 2;
    rdchk(0);
    wr(0, 'h80);
    pin(2, 1'b1);
    rdchk(0);
    lag = 3;
    wr(0, 'h90);
    pin(2, 1'b0);
    wt(10);
    m[0] = 'h12;
    chk(32'(pushes), 2);
    rdchk(0);
    lag = -1;
    wr(0, 'h10);
    slp <= 1'b1;
    wt(2);
    pin(2, 1'b1);
    pin(2, 1'b0);
    chk(32'(wake), 1);
    slp <= 1'b0;
    wr(0, 0);
    wr(8, 'h04);
    pin(2, 1'b1);
    rdchk(9);
    pin(2, 1'b0);
    rdchk(0);
    wr(8, 0);
    wr(3, 'h3f);
    wr(0, 'h88);
    for (k = 0; k < 6; k++) begin
      pin(k, 1'b1);
      m[1] |= 1 << k;
      rdchk(1);
    end
    rdchk(0);
    chk(32'(irq), 1);
    wr(0, 'h80);
    wt(2);
    chk(32'(irq), 0);
    wr(1, 0);
    wr(3, 0);
    wr(2, 'h20);
    pin(4, 1'b0);
    pin(5, 1'b0);
    m[1] = 'h20;
    rdchk(1);
    wr(1, 0);
    pin(5, 1'b1);
    // enabled fall lands while a port access runs: dropped
    pacc <= 1'b1;
    pin(5, 1'b0);
    pacc <= 1'b0;
    rdchk(1);
    wr(5, 'h01);
    pev <= 8'h11;
    wt(1);
    pev <= 8'h00;
    wt(2);
    m[6] |= 1;
    rdchk(6);
    chk(32'(irq), 0);
    wr(0, 'hc0);
    wt(2);
    chk(32'(irq), 1);
    wr(6, 0);
    wt(2);
    chk(32'(irq), 0);
    conclude();
  end
  initial begin
    wt(20000);
    n_mismatch++;
    conclude();
  end
endmodule
